// ===== verilog/udp_timer_pwm.sv
// up/down timer with compare, waveform generator and output logic
`timescale 1ns/1ps
`default_nettype none
`include "udp_timer_defs.svh"
module udp_timer_pwm (
  input wire logic core_clk, // 200 mhz core clock
  input wire logic rst, // async reset, active high
  input wire logic [2:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic we, // write strobe
  input wire logic re, // read strobe
  output logic [15:0] rdata, // read data, cycle after re
  input wire logic ext_clk_in, // external count source
  input wire logic direction_input, // count direction, directional mode
  input wire logic power_drive_protect_n, // protect input, low = fault
  input wire logic higher_prio_pending, // higher priority request in group
  output logic compare_pwm_pin, // pin output value
  output logic compare_pwm_oe_n, // pin enable, low = driving
  output logic adc_start, // adc start pulse
  output logic irq_req // compare interrupt request
);
  udp_pkg::udp_state_t s;
  udp_pkg::udp_state_t n;
  logic [2:0] mode;
  logic [2:0] pscale;
  logic [1:0] clksrc;
  logic [1:0] reload;
  logic run;
  logic cmp_en;
  logic src_tick;
  logic tick;
  logic [6:0] pre_lim;
  logic match;
  logic zero_evt;
  logic is_up;
  logic is_sym;
  logic reload_now;

  assign mode = s.tctl[`UDP_TC_MODE_MSB:`UDP_TC_MODE_LSB];
  assign pscale = s.tctl[`UDP_TC_PRESCALE_MSB:`UDP_TC_PRESCALE_LSB];
  assign clksrc = s.tctl[`UDP_TC_CLKSRC_MSB:`UDP_TC_CLKSRC_LSB];
  assign reload = s.tctl[`UDP_TC_RELOAD_MSB:`UDP_TC_RELOAD_LSB];
  assign run = s.tctl[`UDP_TC_RUN];
  assign cmp_en = s.tctl[`UDP_TC_CMP_EN];
  assign is_up = (mode == `UDP_MODE_SINGLE_UP) || (mode == `UDP_MODE_CONT_UP);
  assign is_sym = (mode == `UDP_MODE_SINGLE_UPDOWN) || (mode == `UDP_MODE_CONT_UPDOWN);

  // ------------------------------------------------------------------
  // prescaler
  // ------------------------------------------------------------------
  assign src_tick = (clksrc == `UDP_SRC_INTERNAL) ? 1'b1 :
                    (clksrc == `UDP_SRC_EXTERNAL) ? (ext_clk_in & ~s.ext_q) : 1'b0; // RULE7
  assign pre_lim = 7'((8'h01 << pscale) - 8'h01);
  assign tick = run && src_tick && (s.pre == pre_lim); // RULE26

  // ------------------------------------------------------------------
  // compare evaluation, one cycle after the counter moves
  // ------------------------------------------------------------------
  assign match = cmp_en && s.evt && (s.cnt == s.cmp_active); // RULE8
  assign zero_evt = s.evt && (s.cnt == 16'h0000);

  always_comb
  begin
    n = s;
    n.ext_q = ext_clk_in;
    n.run_q = run;
    n.evt = tick || (run && !s.run_q);
    n.rdata = 16'h0000;
    reload_now = 1'b0;
    // prescale counter
    if (!run)
    begin
      n.pre = 7'h00; // RULE23
    end
    else if (src_tick)
    begin
      n.pre = (s.pre == pre_lim) ? 7'h00 : s.pre + 7'h01;
    end
    // counter
    if (tick)
    begin
      case (mode)
        `UDP_MODE_SINGLE_UP, `UDP_MODE_CONT_UP:
        begin
          n.dir = 1'b1;
          if (s.cnt == s.period)
          begin
            n.cnt = 16'h0000;
            if (mode == `UDP_MODE_SINGLE_UP)
            begin
              n.tctl[`UDP_TC_RUN] = 1'b0;
            end
          end
          else
          begin
            n.cnt = s.cnt + 16'h0001;
          end
        end
        `UDP_MODE_DIR_UPDOWN:
        begin
          n.dir = direction_input;
          if (direction_input)
          begin
            if ((s.cnt != s.period) && (s.cnt != `UDP_CNT_MAX))
            begin
              n.cnt = s.cnt + 16'h0001;
            end
          end
          else if (s.cnt == 16'h0000)
          begin
            n.cnt = s.period;
          end
          else
          begin
            n.cnt = s.cnt - 16'h0001;
          end
        end
        `UDP_MODE_SINGLE_UPDOWN, `UDP_MODE_CONT_UPDOWN:
        begin
          if (s.dir)
          begin
            if ((s.cnt == s.period) && (s.period != 16'h0000))
            begin
              n.cnt = s.cnt - 16'h0001; // RULE4
              n.dir = 1'b0; // RULE1
            end
            else
            begin
              n.cnt = s.cnt + 16'h0001; // RULE3 RULE5
            end
          end
          else if (s.cnt != 16'h0000)
          begin
            n.cnt = s.cnt - 16'h0001; // RULE2
            if (s.cnt == 16'h0001)
            begin
              n.dir = 1'b1; // RULE1
              if (mode == `UDP_MODE_SINGLE_UPDOWN)
              begin
                n.tctl[`UDP_TC_RUN] = 1'b0;
              end
            end
          end
          else
          begin
            n.dir = 1'b1;
          end
        end
        default:
        begin
          n.cnt = s.cnt; // RULE21
        end
      endcase
      reload_now = (n.cnt == 16'h0000) ||
                   ((reload == `UDP_RELOAD_ZERO_PERIOD) && (n.cnt == s.period));
    end
    // compare reload
    if (((reload == `UDP_RELOAD_ZERO) || (reload == `UDP_RELOAD_ZERO_PERIOD)) && reload_now)
    begin
      n.cmp_active = s.cmp_shadow; // RULE22
    end
    // waveform generator
    n.match_d = match;
    if (is_up) // RULE10
    begin
      if (zero_evt)
      begin
        n.wave = (s.cmp_active == 16'h0000); // RULE13
      end
      if (match)
      begin
        n.wave = 1'b1; // RULE13 RULE14
      end
    end
    else if (is_sym)
    begin
      if (zero_evt)
      begin
        n.second = 1'b0;
        if (s.cmp_active == 16'h0000)
        begin
          n.wave = 1'b1; // RULE16
        end
        else if (!s.second)
        begin
          n.wave = 1'b0; // RULE15
        end
      end
      else if (match)
      begin
        if (!s.dir)
        begin
          n.wave = ~s.wave; // RULE15 RULE17
          n.second = 1'b1;
        end
        else if (s.cmp_active < s.period)
        begin
          n.wave = ~s.wave; // RULE15 RULE17
        end
      end
    end
    // flag, adc start and request; set wins over clear
    n.adc = s.match_d && (s.adc_sel == `UDP_ADC_ON_COMPARE); // RULE11
    // register writes
    if (we)
    begin
      if (addr == `UDP_OFS_TIMER_CONTROL)
      begin
        n.tctl = wdata & `UDP_TC_WMASK;
      end
      else if (addr == `UDP_OFS_GLOBAL_CONTROL)
      begin
        n.adc_sel = wdata[`UDP_GC_ADC_MSB:`UDP_GC_ADC_LSB];
        n.out_en = wdata[`UDP_GC_OUT_EN];
        n.pol = wdata[`UDP_GC_POL_MSB:`UDP_GC_POL_LSB];
      end
      else if (addr == `UDP_OFS_PERIOD)
      begin
        n.period = wdata;
      end
      else if (addr == `UDP_OFS_COMPARE)
      begin
        n.cmp_shadow = wdata;
      end
      else if (addr == `UDP_OFS_COUNTER)
      begin
        n.cnt = wdata;
      end
      else if (addr == `UDP_OFS_FLAGS)
      begin
        if (wdata[`UDP_FL_CMP_FLAG])
        begin
          n.flag = 1'b0;
        end
        n.mask_en = wdata[`UDP_FL_CMP_MASK_EN];
        n.prot_en = wdata[`UDP_FL_PROTECT_EN];
      end
    end
    if (reload == `UDP_RELOAD_NOW)
    begin
      n.cmp_active = n.cmp_shadow; // RULE22
    end
    if (s.match_d)
    begin
      n.flag = 1'b1; // RULE9
    end
    n.irq = s.flag && s.mask_en && !higher_prio_pending; // RULE12
    // output logic
    case (n.pol)
      `UDP_POL_FORCE_LOW: n.pin = 1'b0; // RULE19 RULE24
      `UDP_POL_ACTIVE_LOW: n.pin = ~n.wave; // RULE18 RULE24
      `UDP_POL_ACTIVE_HIGH: n.pin = n.wave; // RULE18 RULE24
      default: n.pin = 1'b1; // RULE19 RULE25
    endcase
    n.pin_oe_n = !(n.out_en && !(s.prot_en && !power_drive_protect_n)); // RULE20
    // register reads
    if (re)
    begin
      if (addr == `UDP_OFS_TIMER_CONTROL)
      begin
        n.rdata = s.tctl;
      end
      else if (addr == `UDP_OFS_GLOBAL_CONTROL)
      begin
        n.rdata[`UDP_GC_DIR_STATUS] = s.dir; // RULE6
        n.rdata[`UDP_GC_ADC_MSB:`UDP_GC_ADC_LSB] = s.adc_sel;
        n.rdata[`UDP_GC_OUT_EN] = s.out_en;
        n.rdata[`UDP_GC_POL_MSB:`UDP_GC_POL_LSB] = s.pol;
      end
      else if (addr == `UDP_OFS_PERIOD)
      begin
        n.rdata = s.period;
      end
      else if (addr == `UDP_OFS_COMPARE)
      begin
        n.rdata = s.cmp_shadow;
      end
      else if (addr == `UDP_OFS_COUNTER)
      begin
        n.rdata = s.cnt;
      end
      else if (addr == `UDP_OFS_FLAGS)
      begin
        n.rdata[`UDP_FL_CMP_FLAG] = s.flag;
        n.rdata[`UDP_FL_CMP_MASK_EN] = s.mask_en;
        n.rdata[`UDP_FL_PROTECT_EN] = s.prot_en;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.dir <= `UDP_RST_DIR;
      s.pin_oe_n <= 1'b1; // RULE20
    end
    else
    begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign compare_pwm_pin = s.pin;
  assign compare_pwm_oe_n = s.pin_oe_n;
  assign adc_start = s.adc;
  assign irq_req = s.irq;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_flag_two_cycles: assert property (match |-> ##2 s.flag) // RULE9
    else $error("compare flag not set two cycles after match");
  a_adc_with_flag: assert property (adc_start |-> s.flag && $rose(s.flag) || $past(s.flag)) // RULE11
    else $error("adc start without compare flag");
  a_updown_turn: assert property (tick && is_sym && s.dir && s.cnt == s.period
      && s.period != 16'h0000 && !we |=> s.cnt == $past(s.period) - 16'h0001 && !s.dir) // RULE1
    else $error("up/down counter did not turn at period");
  a_wrap_at_max: assert property (tick && is_sym && s.dir && s.cnt == `UDP_CNT_MAX
      && s.period != `UDP_CNT_MAX && !we |=> s.cnt == 16'h0000) // RULE3
    else $error("counter did not wrap at ffff");
  a_run_hold: assert property (!run && !we |=> $stable(s.cnt) && s.pre == 7'h00) // RULE23
    else $error("counter moved while stopped");
  a_dir_no_wave: assert property (mode == `UDP_MODE_DIR_UPDOWN && !we |=> $stable(s.wave)) // RULE10
    else $error("waveform moved in directional mode");
  a_force_levels: assert property (##1 s.pol == `UDP_POL_FORCE_HIGH |-> compare_pwm_pin) // RULE19
    else $error("forced high pin not high");
  a_force_low: assert property (##1 s.pol == `UDP_POL_FORCE_LOW |-> !compare_pwm_pin) // RULE24
    else $error("forced low pin not low");
  a_active_high: assert property (s.pol == `UDP_POL_ACTIVE_HIGH |-> compare_pwm_pin == s.wave) // RULE18
    else $error("active high pin differs from waveform");
  a_hiz_disable: assert property (!s.out_en |-> compare_pwm_oe_n) // RULE20
    else $error("pin driven while outputs disabled");
  a_irq_gated: assert property (higher_prio_pending |=> !irq_req) // RULE12
    else $error("request raised over higher priority");

  c_sym_match: cover property (is_sym && match && !s.dir);
  c_flag_set: cover property ($rose(s.flag));
  c_adc_start: cover property (adc_start);
  c_protect_off: cover property (s.out_en && compare_pwm_oe_n);
endmodule : udp_timer_pwm
`default_nettype wire

// ===== verilog/udp_timer_defs.svh
// constants of the up/down timer compare and pwm stage
// ------------------------------------------------------------------
// Behaviour
// RULE1 - continuous up/down counts up to period, down to zero, repeats forever
// RULE2 - each up/down period lasts twice the period value in scaled ticks
// RULE3 - start above period: count to ffff, wrap to zero, continue from zero
// RULE4 - start equal to period: count down to zero first, then continue
// RULE5 - start below period: count up to period, finish period normally
// RULE6 - direction status reads 1 counting up, 0 counting down
// RULE7 - continuous up/down ignores direction input; internal or external source
// RULE8 - with compare enabled, counter equal to compare value is a match
// RULE9 - compare flag sets two core clocks after the match
// RULE10 - waveform moves one clock after match, never in directional mode
// RULE11 - adc start pulses with the compare flag when selected
// RULE12 - interrupt request only when unmasked and no higher group request
// RULE13 - asymmetric: 0 at start, set on match, 0 at period end unless next compare zero
// RULE14 - asymmetric: compare zero all high, above period all low, equal one tick
// RULE15 - symmetric: 0 at start, toggle on both matches, 0 at end if no second
// RULE16 - symmetric: compare zero at start drives 1, stays 1 with zero again
// RULE17 - symmetric: first toggle skipped when compare at or above period
// RULE18 - active high passes waveform, active low inverts it
// RULE19 - forced patterns drive the pin immediately regardless of the generator
// RULE20 - pin high impedance on output disable, unmasked protect low, reset
// RULE21 - mode code 101 is continuous up/down; 110 and 111 undefined
// RULE22 - compare reload at zero (00), zero or period (01), immediately (10)
// RULE23 - run bit clear holds counter and resets prescaler; set allows counting
// RULE24 - polarity 00 forced low, 01 active low, 10 active high
// RULE25 - polarity 11 forced high
// RULE26 - counter advances only on prescaled ticks of the selected source
// ------------------------------------------------------------------
`ifndef UDP_TIMER_DEFS_SVH
`define UDP_TIMER_DEFS_SVH
// register offsets
`define UDP_OFS_TIMER_CONTROL 3'h0
`define UDP_OFS_GLOBAL_CONTROL 3'h1
`define UDP_OFS_PERIOD 3'h2
`define UDP_OFS_COMPARE 3'h3
`define UDP_OFS_COUNTER 3'h4
`define UDP_OFS_FLAGS 3'h5
// timer_control fields
`define UDP_TC_MODE_MSB 13
`define UDP_TC_MODE_LSB 11
`define UDP_TC_PRESCALE_MSB 10
`define UDP_TC_PRESCALE_LSB 8
`define UDP_TC_RUN 6
`define UDP_TC_CLKSRC_MSB 5
`define UDP_TC_CLKSRC_LSB 4
`define UDP_TC_RELOAD_MSB 3
`define UDP_TC_RELOAD_LSB 2
`define UDP_TC_CMP_EN 1
`define UDP_TC_WMASK 16'h3f7e
// global_timer_control fields
`define UDP_GC_DIR_STATUS 13
`define UDP_GC_ADC_MSB 8
`define UDP_GC_ADC_LSB 7
`define UDP_GC_OUT_EN 6
`define UDP_GC_POL_MSB 1
`define UDP_GC_POL_LSB 0
// flags register fields
`define UDP_FL_CMP_FLAG 0
`define UDP_FL_CMP_MASK_EN 1
`define UDP_FL_PROTECT_EN 2
// codes
`define UDP_MODE_HOLD 3'h0
`define UDP_MODE_SINGLE_UP 3'h1
`define UDP_MODE_CONT_UP 3'h2
`define UDP_MODE_DIR_UPDOWN 3'h3
`define UDP_MODE_SINGLE_UPDOWN 3'h4
`define UDP_MODE_CONT_UPDOWN 3'h5
`define UDP_SRC_INTERNAL 2'h0
`define UDP_SRC_EXTERNAL 2'h1
`define UDP_RELOAD_ZERO 2'h0
`define UDP_RELOAD_ZERO_PERIOD 2'h1
`define UDP_RELOAD_NOW 2'h2
`define UDP_POL_FORCE_LOW 2'h0
`define UDP_POL_ACTIVE_LOW 2'h1
`define UDP_POL_ACTIVE_HIGH 2'h2
`define UDP_POL_FORCE_HIGH 2'h3
`define UDP_ADC_ON_COMPARE 2'h3
// reset values and counter maximum
`define UDP_RST_WORD 16'h0000
`define UDP_RST_DIR 1'b1
`define UDP_CNT_MAX 16'hffff
`endif

// ===== verilog/udp_pkg.sv
// types of the up/down timer compare and pwm stage
package udp_pkg;
  typedef struct packed {
    logic [15:0] tctl;
    logic [1:0] adc_sel;
    logic out_en;
    logic [1:0] pol;
    logic [15:0] period;
    logic [15:0] cmp_shadow;
    logic [15:0] cmp_active;
    logic [15:0] cnt;
    logic dir;
    logic [6:0] pre;
    logic ext_q;
    logic run_q;
    logic evt;
    logic match_d;
    logic wave;
    logic second;
    logic flag;
    logic mask_en;
    logic prot_en;
    logic pin;
    logic pin_oe_n;
    logic adc;
    logic irq;
    logic [15:0] rdata;
  } udp_state_t;
endpackage : udp_pkg

// ===== verification/udp_power_stage.sv
// power switch stage model driven by the compare pwm pin
`timescale 1ns/1ps
`default_nettype none
module udp_power_stage (
  input wire logic pin, // pin value from the block
  input wire logic oe_n, // pin enable, low = driven
  output logic gate // level seen by the switch gate
);
  // ------------------------------------------------------------------
  // gate input
  // ------------------------------------------------------------------
  // gate input has a pull-down, so a released pin keeps the switch off
  assign gate = oe_n ? 1'b0 : pin;
endmodule : udp_power_stage
`default_nettype wire

// ===== verification/tb_udp_timer_pwm.sv
// self-checking bench of the up/down timer compare and pwm stage
`timescale 1ns/1ps
`default_nettype none
module tb_udp_timer_pwm;
  logic core_clk, rst, we, re, ext_clk_in, protect_n, higher;
  logic direction_input = 1'b0;
  logic [2:0] addr;
  logic [15:0] wdata, rdata, r, r2;
  logic pin, oe_n, adc_start, irq_req, gate, any_up, all_up;
  int num_errors = 0;
  int samples_checked = 0;
  int adc_n = 0;
  int adc_base = 0;
  logic [1:0] pol_row [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic exp_row [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  udp_timer_pwm dut (
    .core_clk(core_clk), .rst(rst), .addr(addr), .wdata(wdata), .we(we), .re(re),
    .rdata(rdata), .ext_clk_in(ext_clk_in), .direction_input(direction_input),
    .power_drive_protect_n(protect_n), .higher_prio_pending(higher),
    .compare_pwm_pin(pin), .compare_pwm_oe_n(oe_n), .adc_start(adc_start),
    .irq_req(irq_req)
  );
  udp_power_stage load (.pin(pin), .oe_n(oe_n), .gate(gate));

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // direction input wanders; up/down mode must not follow it
  always @(posedge core_clk) direction_input <= ~direction_input;
  // counts pulses at the rising edge so the sequence can read it at the falling edge
  always @(posedge core_clk) if (adc_start === 1'b1) adc_n++;

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge core_clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge core_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge core_clk);
    re <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  // waits for the gate to reach lvl, then counts how long it stays
  task automatic width(input logic lvl, input logic [15:0] e);
    int n;
    int t;
    n = 0;
    t = 0;
    while (gate !== lvl && t < 100)
    begin
      @(negedge core_clk);
      t++;
    end
    while (gate === lvl && t < 100)
    begin
      @(negedge core_clk);
      t++;
      n++;
    end
    if (t >= 100)
    begin
      num_errors++;
      finish_test();
    end
    chk("pulse width", e, 16'(n));
  endtask : width

  // ------------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    ext_clk_in = 1'b0;
    protect_n = 1'b1;
    higher = 1'b0;
    @(negedge core_clk);
    chk("oe_n in reset", 16'h0001, {15'h0, oe_n});
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rd(3'h1, r);
    chk("global control reset", 16'h2000, r);
    rd(3'h0, r);
    chk("timer control reset", 16'h0000, r);
    // output configurations with the generator at rest
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h1, {14'h0010, pol_row[i]});
      cyc(2);
      chk("gate level", {15'h0, exp_row[i]}, {15'h0, gate});
      chk("oe_n enabled", 16'h0000, {15'h0, oe_n});
    end
    // continuous up, period 4: compare 2 gives 3 ticks high, compare 4 one tick
    wr(3'h2, 16'h0004);
    wr(3'h3, 16'h0002);
    wr(3'h1, 16'h01c2);
    wr(3'h0, 16'h104a);
    width(1'b1, 16'h0003);
    width(1'b0, 16'h0002);
    wr(3'h3, 16'h0004);
    width(1'b0, 16'h0004);
    width(1'b1, 16'h0001);
    wr(3'h0, 16'h0000);
    // compare disabled: no output and no adc start
    wr(3'h2, 16'h0004);
    wr(3'h3, 16'h0002);
    wr(3'h1, 16'h01c2);
    wr(3'h0, 16'h2848);
    cyc(1);
    adc_base = adc_n;
    cyc(20);
    chk("gate idle", 16'h0000, {15'h0, gate});
    chk("adc idle", 16'h0000, 16'(adc_n - adc_base));
    wr(3'h0, 16'h0000);
    wr(3'h4, 16'h0000);
    wr(3'h5, 16'h0002);
    // period 4, compare 2, prescale /2: 8 cycles high, 8 low, repeating
    wr(3'h0, 16'h294a);
    width(1'b1, 16'h0008);
    width(1'b0, 16'h0008);
    width(1'b1, 16'h0008);
    adc_base = adc_n;
    cyc(16);
    chk("adc pulses", 16'h0002, 16'(adc_n - adc_base));
    any_up = 1'b0;
    all_up = 1'b1;
    repeat (8)
    begin
      rd(3'h1, r);
      any_up = any_up | r[13];
      all_up = all_up & r[13];
    end
    chk("direction seen up", 16'h0001, {15'h0, any_up});
    chk("direction seen down", 16'h0000, {15'h0, all_up});
    rd(3'h5, r);
    chk("flags", 16'h0003, r);
    chk("irq", 16'h0001, {15'h0, irq_req});
    @(posedge core_clk);
    higher <= 1'b1;
    cyc(2);
    chk("irq blocked", 16'h0000, {15'h0, irq_req});
    wr(3'h5, 16'h0006);
    @(posedge core_clk);
    protect_n <= 1'b0;
    cyc(2);
    chk("oe_n protect", 16'h0001, {15'h0, oe_n});
    @(posedge core_clk);
    protect_n <= 1'b1;
    cyc(2);
    chk("oe_n released", 16'h0000, {15'h0, oe_n});
    wr(3'h1, 16'h0182);
    cyc(2);
    chk("oe_n disabled", 16'h0001, {15'h0, oe_n});
    wr(3'h0, 16'h280a);
    rd(3'h4, r);
    cyc(5);
    rd(3'h4, r2);
    chk("counter held", r, r2);
    rd(3'h6, r);
    chk("unmapped read", 16'h0000, r);
    wr(3'h1, 16'h01c2);
    // directional mode around the compare value: the pin must not move
    wr(3'h4, 16'h0002);
    wr(3'h0, 16'h184a);
    cyc(2);
    r = {15'h0, gate};
    cyc(20);
    chk("gate directional", r, {15'h0, gate});
    wr(3'h0, 16'h284a);
    cyc(5);
    @(posedge core_clk);
    rst <= 1'b1;
    cyc(1);
    chk("oe_n mid reset", 16'h0001, {15'h0, oe_n});
    chk("pin mid reset", 16'h0000, {15'h0, pin});
    // after release: external source, start above period, wrap through ffff
    @(posedge core_clk);
    rst <= 1'b0;
    wr(3'h2, 16'h0004);
    wr(3'h4, 16'hfffe);
    wr(3'h0, 16'h2858);
    cyc(5);
    rd(3'h4, r);
    chk("counter without source edge", 16'hfffe, r);
    repeat (3)
    begin
      @(posedge core_clk);
      ext_clk_in <= 1'b1;
      @(posedge core_clk);
      ext_clk_in <= 1'b0;
    end
    rd(3'h4, r);
    chk("counter wrapped", 16'h0001, r);
    finish_test();
  end
endmodule : tb_udp_timer_pwm
`default_nettype wire
